// ===== rtl/csl_pkg.sv
// shared constants, types and carriers for the card security-level logic
package csl_pkg;
  // register byte offsets
  localparam logic [7:0] CSL_OFS_CTRL     = 8'h00;
  localparam logic [7:0] CSL_OFS_CARD_LVL = 8'h04;
  localparam logic [7:0] CSL_OFS_SECT_LVL = 8'h08;
  localparam logic [7:0] CSL_OFS_PLAIN    = 8'h0c;
  localparam logic [7:0] CSL_OFS_RESTRICT = 8'h10;
  localparam logic [7:0] CSL_OFS_STATUS   = 8'h14;
  // control field positions
  localparam int unsigned CSL_CTRL_L4_DIS  = 0;
  localparam int unsigned CSL_CTRL_RD_NMAC = 1;
  localparam int unsigned CSL_CTRL_UID7    = 2;
  // geometry: 8 sectors of 4 blocks, 2-bit level per sector
  localparam int unsigned CSL_SECT_W = 3;
  localparam int unsigned CSL_NSECT  = 8;
  localparam int unsigned CSL_NBLK   = 32;
  // level encoding, upgrades only go upward numerically
  localparam logic [1:0] CSL_LVL_ONE   = 2'h1;
  localparam logic [1:0] CSL_LVL_MIX   = 2'h2;
  localparam logic [1:0] CSL_LVL_THREE = 2'h3;
  // values after reset, and the mac chain step
  localparam logic [2:0]  CSL_RST_CTRL     = 3'h0;
  localparam logic [1:0]  CSL_RST_CARD_LVL = 2'h1;
  localparam logic [15:0] CSL_RST_SECT_LVL = 16'h5555;
  localparam logic [31:0] CSL_RST_PLAIN    = 32'h0000_0000;
  localparam logic [31:0] CSL_RST_RESTRICT = 32'h0000_0000;
  localparam logic [7:0]  CSL_CHAIN_STEP   = 8'h01;
  // answer status codes
  localparam logic [3:0] CSL_STS_OK   = 4'h0;
  localparam logic [3:0] CSL_STS_CMD  = 4'h1;
  localparam logic [3:0] CSL_STS_AUTH = 4'h2;
  localparam logic [3:0] CSL_STS_MAC  = 4'h3;
  localparam logic [3:0] CSL_STS_PERM = 4'h4;

  typedef enum logic [3:0] {
    op_none, op_reqa, op_halt, op_sel_cl1, op_sel_cl2, op_l4_act, op_deselect,
    op_legacy_auth, op_auth_first, op_auth_followup, op_read, op_write, op_key_update
  } csl_op_e;

  typedef enum logic [1:0] {
    key_card_auth, key_switch, key_origin, key_sector
  } csl_key_e;

  typedef enum logic [2:0] {
    st_idle, st_cl2_wait, st_l3_active, st_legacy_auth, st_aes_l1_auth, st_l4_active, st_l4_auth
  } csl_fsm_e;

  // decoded command from the frame front end, with cipher engine verdicts
  typedef struct packed {
    logic                  valid;
    csl_op_e               op;
    csl_key_e              key;
    logic [CSL_SECT_W-1:0] sector;
    logic [1:0]            block;
    logic                  cmd_mac;
    logic                  resp_mac_req;
    logic                  plain;
    logic                  crypto_ok;
    logic                  mac_ok;
  } csl_cmd_s;

  // verdict returned one cycle after a command
  typedef struct packed {
    logic       valid;
    logic       accept;
    logic [3:0] status;
    logic [1:0] uid_part;
    logic       resp_mac;
    logic       legacy_cipher;
    logic       key_load;
    logic       key_clear;
    logic       mem_change;
    logic       chain_restart;
    logic [7:0] chain_cnt;
  } csl_resp_s;

  // apb request side
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } csl_apb_req_s;

  // every flip-flop of the block
  typedef struct packed {
    csl_fsm_e    fsm;
    logic [1:0]  card_lvl;
    logic        sw_pend;
    logic [15:0] sect_lvl;
    logic [2:0]  ctrl;
    logic [31:0] plain;
    logic [31:0] restrict_upd;
    logic [7:0]  chain;
    csl_resp_s   resp;
    logic [31:0] prdata;
    logic        pslverr;
  } csl_state_s;
endpackage

// ===== rtl/csl_card_security_level_state_logic.sv
// security-level state logic of a contactless card with apb registers
`timescale 1ns/1ps

// How it works
// - after anticollision reader picks legacy or layer4
// - legacy cipher auth enters legacy authenticated state
// - card-auth-key aes accepted anytime in legacy mode
// - level-one aes success drops legacy authentication
// - originality, keys, switch key need layer4
// - switch key first/followup, level3 after reactivation
// - mixed sectors: legacy at layer3, aes at layer4
// - legacy path: update restrictions, legacy cipher
// - layer4 activation refused at level one when disabled by config
// - level three: layer4 only, aes keys only
// - level three: layer3, layer4, then authenticate
// - layer4 aes auth loads two session keys
// - bad command mac rejects the command
// - option lets reads skip command mac
// - layer4 writes always need valid mac
// - response mac only when reader asks
// - mac chain spans first-auth to first-auth
// - per-block plaintext permission enforced
// - cascade level two only for 7-byte identifier
// - level changes only upward, never down
module csl_card_security_level_state_logic (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // apb slave
  input  wire csl_pkg::csl_apb_req_s apb_req,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // command in, verdict out
  input  wire csl_pkg::csl_cmd_s     cmd_in,
  output csl_pkg::csl_resp_s         resp_out,
  // level and layer state
  output logic [1:0]                 card_level,
  output logic                       layer4_active,
  output logic                       switch_pending
);
  import csl_pkg::*;

  csl_state_s st_ff;
  csl_state_s nxt_st;

  logic                    wr_en;
  logic                    in_l3;
  logic                    in_l4;
  logic [1:0]              slvl;
  logic [4:0]              blk_idx;
  logic                    l4_sector_ok;
  logic                    key_allowed;
  logic                    ok;
  logic [3:0]              sts;

  // apb handshake, zero wait states
  assign pready  = apb_req.psel && apb_req.penable;
  assign wr_en   = pready && apb_req.pwrite;
  assign prdata  = st_ff.prdata;
  assign pslverr = st_ff.pslverr;

  // outputs from flip-flops
  assign resp_out       = st_ff.resp;
  assign card_level     = st_ff.card_lvl;
  assign switch_pending = st_ff.sw_pend;
  assign layer4_active  = (st_ff.fsm == st_l4_active) || (st_ff.fsm == st_l4_auth);

  // helpers about the addressed sector and current layer
  assign in_l3   = (st_ff.fsm == st_l3_active) || (st_ff.fsm == st_legacy_auth) ||
                   (st_ff.fsm == st_aes_l1_auth);
  assign in_l4   = layer4_active;
  assign slvl    = st_ff.sect_lvl[{cmd_in.sector, 1'b0} +: 2];
  assign blk_idx = {cmd_in.sector, cmd_in.block};
  // aes secure messaging at layer4 only for level3 card or level3/mixed sector
  assign l4_sector_ok = (st_ff.card_lvl == CSL_LVL_THREE) || (slvl != CSL_LVL_ONE);

  // which keys layer4 accepts at the current card level
  always_comb
  begin
    case (cmd_in.key)
      key_origin:    key_allowed = 1'b1;
      key_switch:    key_allowed = (st_ff.card_lvl == CSL_LVL_ONE);
      key_card_auth: key_allowed = (st_ff.card_lvl == CSL_LVL_ONE);
      key_sector:    key_allowed = l4_sector_ok;
      default:       key_allowed = 1'b0;
    endcase
  end

  // next state: registers, then command handling
  always_comb
  begin
    nxt_st                    = st_ff;
    ok                        = 1'b0;
    sts                       = CSL_STS_CMD;
    nxt_st.resp.valid         = 1'b0;
    nxt_st.resp.accept        = 1'b0;
    nxt_st.resp.uid_part      = 2'h0;
    nxt_st.resp.resp_mac      = 1'b0;
    nxt_st.resp.legacy_cipher = 1'b0;
    nxt_st.resp.key_load      = 1'b0;
    nxt_st.resp.key_clear     = 1'b0;
    nxt_st.resp.mem_change    = 1'b0;
    nxt_st.resp.chain_restart = 1'b0;

    // read data and error captured in the setup cycle
    if (apb_req.psel && !apb_req.penable)
    begin
      nxt_st.prdata  = 32'h0000_0000;
      nxt_st.pslverr = 1'b0;
      case (apb_req.paddr)
        CSL_OFS_CTRL:     nxt_st.prdata = {29'h0, st_ff.ctrl};
        CSL_OFS_CARD_LVL: nxt_st.prdata = {30'h0, st_ff.card_lvl};
        CSL_OFS_SECT_LVL: nxt_st.prdata = {16'h0, st_ff.sect_lvl};
        CSL_OFS_PLAIN:    nxt_st.prdata = st_ff.plain;
        CSL_OFS_RESTRICT: nxt_st.prdata = st_ff.restrict_upd;
        CSL_OFS_STATUS:   nxt_st.prdata = {20'h0, st_ff.chain, st_ff.sw_pend, st_ff.fsm};
        default:          nxt_st.pslverr = 1'b1;
      endcase
    end

    // register writes, levels only move upward
    if (wr_en)
    begin
      case (apb_req.paddr)
        CSL_OFS_CTRL:     nxt_st.ctrl = apb_req.pwdata[2:0];
        CSL_OFS_CARD_LVL:
          if (apb_req.pwdata[1:0] > st_ff.card_lvl && apb_req.pwdata[1:0] != CSL_LVL_MIX)
            nxt_st.card_lvl = apb_req.pwdata[1:0];
        CSL_OFS_SECT_LVL:
          for (int i = 0; i < CSL_NSECT; i++)
          begin
            if (apb_req.pwdata[2*i +: 2] > st_ff.sect_lvl[2*i +: 2])
              nxt_st.sect_lvl[2*i +: 2] = apb_req.pwdata[2*i +: 2];
          end
        CSL_OFS_PLAIN:    nxt_st.plain = apb_req.pwdata;
        CSL_OFS_RESTRICT: nxt_st.restrict_upd = apb_req.pwdata;
        default: ;
      endcase
    end

    // command interpreter
    if (cmd_in.valid)
    begin
      nxt_st.resp.valid = 1'b1;
      case (cmd_in.op)
        // wake-up: a pending switch takes effect here
        op_reqa:
        begin
          ok                    = 1'b1;
          nxt_st.fsm            = st_idle;
          nxt_st.resp.key_clear = 1'b1;
          if (st_ff.sw_pend)
          begin
            nxt_st.card_lvl = CSL_LVL_THREE;
            nxt_st.sw_pend  = 1'b0;
          end
        end
        op_halt, op_deselect:
        begin
          ok                    = 1'b1;
          nxt_st.fsm            = st_idle;
          nxt_st.resp.key_clear = 1'b1;
        end
        // cascade level one gives first identifier part
        op_sel_cl1:
          if (st_ff.fsm == st_idle)
          begin
            ok                   = 1'b1;
            nxt_st.resp.uid_part = 2'h1;
            nxt_st.fsm           = st_ff.ctrl[CSL_CTRL_UID7] ? st_cl2_wait : st_l3_active;
          end
        // cascade level two only for the long identifier
        op_sel_cl2:
          if (st_ff.fsm == st_cl2_wait && st_ff.ctrl[CSL_CTRL_UID7])
          begin
            ok                   = 1'b1;
            nxt_st.resp.uid_part = 2'h2;
            nxt_st.fsm           = st_l3_active;
          end
        // layer4 activation straight after selection
        op_l4_act:
          if (st_ff.fsm == st_l3_active &&
              !(st_ff.card_lvl == CSL_LVL_ONE && st_ff.ctrl[CSL_CTRL_L4_DIS]))
          begin
            ok         = 1'b1;
            nxt_st.fsm = st_l4_active;
          end
        // legacy stream-cipher authentication
        op_legacy_auth:
          if (in_l3 && st_ff.card_lvl != CSL_LVL_THREE && slvl != CSL_LVL_THREE)
          begin
            if (cmd_in.crypto_ok)
            begin
              ok                        = 1'b1;
              nxt_st.fsm                = st_legacy_auth;
              nxt_st.resp.legacy_cipher = 1'b1;
            end
            else
            begin
              sts        = CSL_STS_AUTH;
              nxt_st.fsm = st_l3_active;
            end
          end
        // aes authentication, first or followup
        op_auth_first, op_auth_followup:
          if (in_l3 && st_ff.card_lvl == CSL_LVL_ONE && cmd_in.key == key_card_auth)
          begin
            if (cmd_in.crypto_ok)
            begin
              ok         = 1'b1;
              nxt_st.fsm = st_aes_l1_auth;
            end
            else
            begin
              sts        = CSL_STS_AUTH;
              nxt_st.fsm = st_l3_active;
            end
          end
          else if (in_l4 && key_allowed)
          begin
            if (cmd_in.crypto_ok)
            begin
              ok                   = 1'b1;
              nxt_st.fsm           = st_l4_auth;
              nxt_st.resp.key_load = 1'b1;
              if (cmd_in.op == op_auth_first)
              begin
                nxt_st.chain              = 8'h00;
                nxt_st.resp.chain_restart = 1'b1;
              end
              if (cmd_in.key == key_switch)
                nxt_st.sw_pend = 1'b1;
            end
            else
            begin
              sts                   = CSL_STS_AUTH;
              nxt_st.fsm            = st_l4_active;
              nxt_st.resp.key_clear = 1'b1;
            end
          end
        // data access and key updates
        op_read, op_write, op_key_update:
          if (st_ff.fsm == st_legacy_auth && cmd_in.op != op_key_update && slvl != CSL_LVL_THREE)
          begin
            if (cmd_in.op == op_write && st_ff.restrict_upd[blk_idx])
              sts = CSL_STS_PERM;
            else
            begin
              ok                        = 1'b1;
              nxt_st.resp.legacy_cipher = 1'b1;
              nxt_st.resp.mem_change    = (cmd_in.op == op_write);
            end
          end
          else if (st_ff.fsm == st_l4_auth && (l4_sector_ok || cmd_in.op == op_key_update))
          begin
            if (cmd_in.cmd_mac && !cmd_in.mac_ok)
            begin
              sts                   = CSL_STS_MAC;
              nxt_st.fsm            = st_l4_active;
              nxt_st.resp.key_clear = 1'b1;
            end
            else if (!cmd_in.cmd_mac && (cmd_in.op != op_read || !st_ff.ctrl[CSL_CTRL_RD_NMAC]))
              sts = CSL_STS_MAC;
            else if (cmd_in.plain && cmd_in.op != op_key_update && !st_ff.plain[blk_idx])
              sts = CSL_STS_PERM;
            else
            begin
              ok                     = 1'b1;
              nxt_st.resp.mem_change = (cmd_in.op != op_read);
              nxt_st.resp.resp_mac   = cmd_in.resp_mac_req;
              nxt_st.chain           = st_ff.chain + CSL_CHAIN_STEP;
            end
          end
        default: ;
      endcase
      if (ok)
        sts = CSL_STS_OK;
      nxt_st.resp.accept    = ok;
      nxt_st.resp.status    = sts;
      nxt_st.resp.chain_cnt = nxt_st.chain;
    end
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_ff              <= '0;
      st_ff.fsm          <= st_idle;
      st_ff.card_lvl     <= CSL_RST_CARD_LVL;
      st_ff.sect_lvl     <= CSL_RST_SECT_LVL;
      st_ff.ctrl         <= CSL_RST_CTRL;
      st_ff.plain        <= CSL_RST_PLAIN;
      st_ff.restrict_upd <= CSL_RST_RESTRICT;
    end
    else
      st_ff <= nxt_st;
  end

  // checks on the verdicts and the card level
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_l4_refused: assert property (cmd_in.valid && cmd_in.op == op_l4_act && !layer4_active
    && st_ff.card_lvl == CSL_LVL_ONE && st_ff.ctrl[CSL_CTRL_L4_DIS]
    |=> resp_out.valid && !resp_out.accept && !layer4_active)
    else $error("layer4 activation not refused");
  a_write_mac_need: assert property (cmd_in.valid && cmd_in.op == op_write && st_ff.fsm == st_l4_auth
    && l4_sector_ok && !cmd_in.cmd_mac |=> !resp_out.mem_change && resp_out.status == CSL_STS_MAC)
    else $error("write without mac changed memory");
  a_resp_mac_asked: assert property (resp_out.resp_mac |-> $past(cmd_in.resp_mac_req)
    && $past(layer4_active) && resp_out.accept)
    else $error("response mac without request");
  a_aes_drops_legacy: assert property (cmd_in.valid && cmd_in.op == op_auth_first
    && st_ff.fsm == st_legacy_auth && st_ff.card_lvl == CSL_LVL_ONE
    && cmd_in.key == key_card_auth && cmd_in.crypto_ok |=> st_ff.fsm == st_aes_l1_auth)
    else $error("aes success kept legacy state");
  a_l3_no_legacy: assert property (cmd_in.valid && cmd_in.op == op_legacy_auth
    && st_ff.card_lvl == CSL_LVL_THREE |=> !resp_out.accept && st_ff.fsm != st_legacy_auth)
    else $error("legacy auth accepted in level three");
  a_fail_clears: assert property (cmd_in.valid && cmd_in.op == op_auth_first && layer4_active
    && key_allowed && !cmd_in.crypto_ok |=> resp_out.key_clear && resp_out.status == CSL_STS_AUTH
    && st_ff.fsm == st_l4_active)
    else $error("failed auth did not drop session");
  a_level_no_down: assert property (##1 st_ff.card_lvl >= $past(st_ff.card_lvl))
    else $error("card level went down");
  a_chain_restart: assert property (cmd_in.valid && cmd_in.op == op_auth_first && layer4_active
    && key_allowed && cmd_in.crypto_ok |=> resp_out.chain_restart && resp_out.chain_cnt == 8'h00)
    else $error("mac chain not restarted");
  a_cl2_uid7_only: assert property (resp_out.uid_part == 2'h2 |-> $past(st_ff.ctrl[CSL_CTRL_UID7])
    && $past(st_ff.fsm) == st_cl2_wait)
    else $error("cascade two without long identifier");
  a_switch_defer: assert property (switch_pending && !(cmd_in.valid && cmd_in.op == op_reqa)
    |=> card_level == $past(card_level))
    else $error("level three before reactivation");

  c_legacy_auth: cover property (resp_out.accept && st_ff.fsm == st_legacy_auth);
  c_l4_write: cover property (resp_out.accept && resp_out.mem_change && resp_out.resp_mac);
  c_switch_done: cover property (switch_pending ##[1:20] card_level == CSL_LVL_THREE);
  c_mac_fail: cover property (resp_out.valid && resp_out.status == CSL_STS_MAC && resp_out.key_clear);
endmodule

// ===== test/csl_reader_model.sv
// proximity reader stand-in that sends one command and collects the verdict
`timescale 1ns/1ps
module csl_reader_model (
  // clock
  input  wire logic               ref_clk,
  // command out, verdict back
  output csl_pkg::csl_cmd_s       cmd_out,
  input  wire csl_pkg::csl_resp_s resp_in
);
  import csl_pkg::*;

  // idle command line at time zero
  initial cmd_out = '0;

  // one-cycle command pulse, then scrambled idle fields, verdict one cycle later
  task automatic xfer(input csl_cmd_s c, output csl_resp_s r);
    csl_cmd_s idle;
    idle = ~c;
    idle.valid = 1'b0;
    @(posedge ref_clk);
    cmd_out <= c;
    @(posedge ref_clk);
    cmd_out <= idle;
    @(posedge ref_clk);
    r = resp_in;
  endtask
endmodule

// ===== test/csl_card_security_level_state_logic_bench.sv
// self-checking bench for the card security-level state logic
`timescale 1ns/1ps
module csl_card_security_level_state_logic_bench;
  import csl_pkg::*;
  localparam logic [4:0] FN = 5'h00; // no flags
  localparam logic [4:0] FC = 5'h02; // cipher ok
  localparam logic [4:0] FM = 5'h11; // good command mac
  localparam logic [4:0] FR = 5'h19; // good mac, response mac asked
  localparam logic [4:0] FB = 5'h10; // bad command mac
  localparam logic [3:0] NA = 4'hf;  // status not judged
  logic         ref_clk;
  logic         srst;
  logic         pready;
  logic         pslverr;
  logic         err;
  logic         layer4_active;
  logic         switch_pending;
  logic [1:0]   card_level;
  logic [31:0]  prdata;
  logic [31:0]  rv;
  csl_apb_req_s apb_req;
  csl_cmd_s     cmd;
  csl_resp_s    resp_out;
  csl_resp_s    r;
  int           fails;
  int           check_count;

  csl_card_security_level_state_logic dut (
    .ref_clk(ref_clk), .srst(srst), .apb_req(apb_req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cmd_in(cmd), .resp_out(resp_out), .card_level(card_level),
    .layer4_active(layer4_active), .switch_pending(switch_pending)
  );
  csl_reader_model reader (.ref_clk(ref_clk), .cmd_out(cmd), .resp_in(resp_out));

  // 125 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic tally_and_finish();
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fails++;
      tally_and_finish();
    end
    rv = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask

  // register read against an expected word
  task automatic rdr(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rv, exp);
    chk(err, 1'b0);
  endtask

  // one command, judged on accept and status
  task automatic cm(input csl_op_e o, input csl_key_e k, input logic [2:0] s, input logic [1:0] b,
                    input logic [4:0] f, input logic acc, input logic [3:0] st);
    csl_cmd_s c;
    c = '{1'b1, o, k, s, b, f[4], f[3], f[2], f[1], f[0]};
    reader.xfer(c, r);
    chk(r.valid, 1'b1);
    chk(r.accept, acc);
    if (st != NA)
      chk(r.status, st);
  endtask

  // layer-3 activation up to the first cascade level
  task automatic act();
    cm(op_reqa, key_card_auth, 3'h0, 2'h0, FN, 1'b1, CSL_STS_OK);
    chk(r.key_clear, 1'b1);
    cm(op_sel_cl1, key_card_auth, 3'h0, 2'h0, FN, 1'b1, CSL_STS_OK);
    chk(r.uid_part, 2'h1);
  endtask

  // values after reset and an unmapped access
  task automatic s_reset();
    chk(card_level, CSL_RST_CARD_LVL);
    chk(layer4_active, 1'b0);
    rdr(CSL_OFS_CTRL, 32'h0000_0000);
    rdr(CSL_OFS_CARD_LVL, 32'h0000_0001);
    rdr(CSL_OFS_SECT_LVL, 32'h0000_5555);
    rdr(CSL_OFS_PLAIN, 32'h0000_0000);
    rdr(CSL_OFS_RESTRICT, 32'h0000_0000);
    rdr(CSL_OFS_STATUS, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rv, 32'h0000_0000);
  endtask

  // second cascade level only for the long identifier
  task automatic s_uid();
    act();
    cm(op_sel_cl2, key_card_auth, 3'h0, 2'h0, FN, 1'b0, CSL_STS_CMD);
    apb(1'b1, CSL_OFS_CTRL, 32'h0000_0004);
    act();
    cm(op_sel_cl2, key_card_auth, 3'h0, 2'h0, FN, 1'b1, CSL_STS_OK);
    chk(r.uid_part, 2'h2);
    apb(1'b1, CSL_OFS_CTRL, 32'h0000_0000);
  endtask

  // legacy mode, restrictions, optional aes, mixed sector
  task automatic s_level_one();
    apb(1'b1, CSL_OFS_SECT_LVL, 32'h0000_5559);
    apb(1'b1, CSL_OFS_SECT_LVL, 32'h0000_5555);
    rdr(CSL_OFS_SECT_LVL, 32'h0000_5559);
    apb(1'b1, CSL_OFS_RESTRICT, 32'h0000_0002);
    act();
    cm(op_auth_first, key_origin, 3'h0, 2'h0, FC, 1'b0, NA);
    cm(op_legacy_auth, key_sector, 3'h0, 2'h0, FC, 1'b1, CSL_STS_OK);
    chk(r.legacy_cipher, 1'b1);
    cm(op_write, key_sector, 3'h0, 2'h1, FN, 1'b0, NA);
    chk(r.mem_change, 1'b0);
    cm(op_write, key_sector, 3'h0, 2'h2, FN, 1'b1, CSL_STS_OK);
    chk(r.legacy_cipher, 1'b1);
    cm(op_key_update, key_sector, 3'h0, 2'h0, FM, 1'b0, CSL_STS_CMD);
    cm(op_auth_first, key_card_auth, 3'h0, 2'h0, FC, 1'b1, CSL_STS_OK);
    chk(r.key_load, 1'b0);
    cm(op_read, key_sector, 3'h0, 2'h2, FN, 1'b0, NA);
    cm(op_legacy_auth, key_sector, 3'h1, 2'h0, FC, 1'b1, CSL_STS_OK);
  endtask

  // layer-4 gate, layer-4-only keys and the switch to level three
  task automatic s_layer4();
    apb(1'b1, CSL_OFS_CTRL, 32'h0000_0001);
    act();
    cm(op_l4_act, key_card_auth, 3'h0, 2'h0, FN, 1'b0, NA);
    chk(layer4_active, 1'b0);
    apb(1'b1, CSL_OFS_CTRL, 32'h0000_0000);
    act();
    cm(op_l4_act, key_card_auth, 3'h0, 2'h0, FN, 1'b1, CSL_STS_OK);
    chk(layer4_active, 1'b1);
    cm(op_auth_first, key_origin, 3'h0, 2'h0, FC, 1'b1, CSL_STS_OK);
    cm(op_key_update, key_origin, 3'h0, 2'h0, FM, 1'b1, CSL_STS_OK);
    chk(r.mem_change, 1'b1);
    chk(r.chain_cnt, 8'h01);
    cm(op_auth_first, key_sector, 3'h0, 2'h0, FC, 1'b0, NA);
    cm(op_auth_first, key_sector, 3'h1, 2'h0, FC, 1'b1, CSL_STS_OK);
    cm(op_auth_followup, key_switch, 3'h0, 2'h0, FC, 1'b1, CSL_STS_OK);
    chk(switch_pending, 1'b1);
    chk(card_level, CSL_LVL_ONE);
    act();
    chk(card_level, CSL_LVL_THREE);
    chk(switch_pending, 1'b0);
    apb(1'b1, CSL_OFS_CARD_LVL, 32'h0000_0001);
    rdr(CSL_OFS_CARD_LVL, 32'h0000_0003);
  endtask

  // level three: sessions, command and response macs, chaining, plaintext
  task automatic s_level_three();
    cm(op_legacy_auth, key_sector, 3'h2, 2'h0, FC, 1'b0, NA);
    act();
    cm(op_l4_act, key_card_auth, 3'h0, 2'h0, FN, 1'b1, CSL_STS_OK);
    cm(op_read, key_sector, 3'h2, 2'h0, FM, 1'b0, NA);
    cm(op_auth_first, key_sector, 3'h2, 2'h0, FN, 1'b0, CSL_STS_AUTH);
    chk(r.key_clear, 1'b1);
    cm(op_auth_first, key_sector, 3'h2, 2'h0, FC, 1'b1, CSL_STS_OK);
    chk(r.key_load, 1'b1);
    chk(r.chain_restart, 1'b1);
    cm(op_read, key_sector, 3'h2, 2'h0, FN, 1'b0, CSL_STS_MAC);
    apb(1'b1, CSL_OFS_CTRL, 32'h0000_0002);
    cm(op_read, key_sector, 3'h2, 2'h0, FN, 1'b1, CSL_STS_OK);
    chk(r.resp_mac, 1'b0);
    chk(r.chain_cnt, 8'h01);
    cm(op_write, key_sector, 3'h2, 2'h0, FN, 1'b0, CSL_STS_MAC);
    chk(r.mem_change, 1'b0);
    cm(op_write, key_sector, 3'h2, 2'h0, FR, 1'b1, CSL_STS_OK);
    chk(r.mem_change, 1'b1);
    chk(r.resp_mac, 1'b1);
    chk(r.chain_cnt, 8'h02);
    cm(op_read, key_sector, 3'h2, 2'h1, 5'h15, 1'b0, CSL_STS_PERM);
    apb(1'b1, CSL_OFS_PLAIN, 32'h0000_0200);
    cm(op_read, key_sector, 3'h2, 2'h1, 5'h15, 1'b1, CSL_STS_OK);
    cm(op_read, key_sector, 3'h2, 2'h0, FR, 1'b1, CSL_STS_OK);
    chk(r.resp_mac, 1'b1);
    cm(op_auth_followup, key_sector, 3'h2, 2'h0, FC, 1'b1, CSL_STS_OK);
    chk(r.chain_restart, 1'b0);
    cm(op_auth_first, key_sector, 3'h2, 2'h0, FC, 1'b1, CSL_STS_OK);
    cm(op_write, key_sector, 3'h2, 2'h0, FM, 1'b1, CSL_STS_OK);
    chk(r.chain_cnt, 8'h01);
    cm(op_write, key_sector, 3'h2, 2'h0, FB, 1'b0, CSL_STS_MAC);
    chk(r.key_clear, 1'b1);
    chk(r.mem_change, 1'b0);
    chk(layer4_active, 1'b1);
    cm(op_write, key_sector, 3'h2, 2'h0, FM, 1'b0, NA);
    cm(op_deselect, key_sector, 3'h2, 2'h0, FN, 1'b1, CSL_STS_OK);
    chk(r.key_clear, 1'b1);
    chk(layer4_active, 1'b0);
    act();
    cm(op_halt, key_sector, 3'h2, 2'h0, FN, 1'b1, CSL_STS_OK);
    chk(r.key_clear, 1'b1);
    cm(op_l4_act, key_card_auth, 3'h0, 2'h0, FN, 1'b0, CSL_STS_CMD);
  endtask

  // main sequence
  initial
  begin
    srst = 1'b1;
    apb_req = '0;
    fails = 0;
    check_count = 0;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    s_reset();
    s_uid();
    s_level_one();
    s_layer4();
    s_level_three();
    tally_and_finish();
  end

  // hang guard
  initial
  begin
    #400000;
    fails++;
    tally_and_finish();
  end
endmodule
